//--- inc/dcd_pkg.sv
// Notes on behaviour
// RQ1: Under read protection, register writes land only in flash control registers.
// RQ2: Under read protection, flash command register accepts only the mass-erase code.
// RQ3: Under read protection, commands 09H, 0AH, 0BH, 10H, 11H, 12H are refused.
// RQ4: Command 00H answers revision high byte first, then low byte.
// RQ5: Command 02H answers exactly one byte holding the status byte.
// RQ6: Runtime counter counts clock cycles while running, readable by command 03H.
// RQ7: Runtime counter is 16 bits, starts at 0000H, saturates at FFFFH.
// RQ8: Host sends command byte and data first, then takes reply bytes in order.
// RQ9: Codes 0FH and 13H to FFH are ignored and give no reply.
// RQ10: Write data memory 0CH stays allowed under read protection.
package dcd_pkg;
    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_READ_REV = 8'h00;
    localparam logic [7:0] CMD_READ_STATUS = 8'h02;
    localparam logic [7:0] CMD_READ_RUNTIME = 8'h03;
    localparam logic [7:0] CMD_WRITE_REG = 8'h08;
    localparam logic [7:0] CMD_READ_REG = 8'h09;
    localparam logic [7:0] CMD_WRITE_PROG = 8'h0a;
    localparam logic [7:0] CMD_READ_PROG = 8'h0b;
    localparam logic [7:0] CMD_WRITE_DATA = 8'h0c;
    localparam logic [7:0] CMD_RESERVED_LONE = 8'h0f;
    localparam logic [7:0] CMD_STEP = 8'h10;
    localparam logic [7:0] CMD_STUFF = 8'h11;
    localparam logic [7:0] CMD_EXEC = 8'h12;
    localparam logic [7:0] CMD_RESERVED_FIRST = 8'h13;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int REG_ADDR_W = 12;
    localparam logic [15:0] RUNTIME_RESET = 16'h0000;
    localparam logic [15:0] RUNTIME_MAX = 16'hffff;
    localparam logic [11:0] ADDR_RESET = 12'h000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] LEFT_RESET = 2'h0;

    typedef enum {
        ST_IDLE, ST_WR_AH, ST_WR_AL, ST_WR_CNT, ST_WR_DATA, ST_REPLY, ST_FWD, ST_DISCARD
    } dcd_state_t;
endpackage

//--- inc/dcd_rt_if.sv
// Runtime counter control and value between decoder and counter
interface dcd_rt_if;
    logic run;
    logic clear;
    logic [15:0] count;
    modport counter(input run, input clear, output count);
    modport user(output run, output clear, input count);
endinterface

//--- design/dcd_runtime_counter.sv
module dcd_runtime_counter
    import dcd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control and value
    dcd_rt_if.counter rt
);
    // ****************************************
    // Saturating counter
    // ****************************************
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic atMax;

    // Holding at the top keeps a long run from reading back as a short one
    assign atMax = (count_r == RUNTIME_MAX);
    assign count_nxt = rt.clear ? RUNTIME_RESET :
                       (rt.run && !atMax) ? count_r + 16'h0001 : count_r; // RQ6 RQ7
    assign rt.count = count_r;

    // Counter register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_r <= RUNTIME_RESET;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    rt_count_up_a: assert property (@(posedge clk) disable iff (!nrst) // RQ6
        (rt.run && !rt.clear && count_r != RUNTIME_MAX) |=> count_r == $past(count_r) + 16'h0001)
        else $error("runtime counter did not advance");
    rt_saturate_a: assert property (@(posedge clk) disable iff (!nrst) // RQ7
        (count_r == RUNTIME_MAX && !rt.clear) |=> count_r == RUNTIME_MAX)
        else $error("runtime counter left its maximum");
    rt_restart_a: assert property (@(posedge clk) disable iff (!nrst) // RQ7
        rt.clear |=> count_r == RUNTIME_RESET)
        else $error("runtime counter did not restart from zero");
endmodule

//--- design/dcd_top.sv
module dcd_top
    import dcd_pkg::*;
#(
    // Revision word; value is arbitrary
    parameter logic [15:0] REV_WORD = 16'h0100,
    // Flash control register window and its command register
    parameter logic [11:0] FLASH_CTL_LO = 12'hff0,
    parameter logic [11:0] FLASH_CTL_HI = 12'hfff,
    parameter logic [11:0] FLASH_CMD_ADDR = 12'hff0,
    parameter logic [7:0] MASS_ERASE_CODE = 8'h5a
)(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Received link bytes
    input wire logic [7:0] rxByte,
    input wire logic rxValid,
    input wire logic linkBreak,
    // Reply bytes to the link
    output logic [7:0] txByte,
    output logic txValid,
    input wire logic txReady,
    // Device state
    input wire logic readProtect,
    input wire logic [7:0] statusByte,
    input wire logic cpuRunning,
    // Register write port
    output logic regWrEn,
    output logic [11:0] regWrAddr,
    output logic [7:0] regWrData,
    output logic regWrRefused,
    // Other commands handed to the debug unit
    output logic cmdStart,
    output logic [7:0] cmdCode,
    output logic cmdRefused,
    output logic fwdValid,
    output logic [7:0] fwdByte,
    input wire logic cmdDone
);
    // ****************************************
    // State and registers
    // ****************************************
    dcd_state_t state_r, state_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic [7:0] wrCount_r, wrCount_nxt;
    logic [7:0] txByte_r, txByte_nxt;
    logic [7:0] replyLow_r, replyLow_nxt;
    logic [1:0] replyLeft_r, replyLeft_nxt;
    logic regWrEn_r, regWrRefused_r, cmdStart_r, cmdRefused_r, fwdValid_r;
    logic [11:0] regWrAddr_r;
    logic [7:0] regWrData_r, cmdCode_r, fwdByte_r;
    logic runPrev_r;

    dcd_rt_if rt();

    // Runtime counter restarts as the CPU leaves a breakpoint
    assign rt.run = cpuRunning;
    assign rt.clear = cpuRunning && !runPrev_r;

    dcd_runtime_counter uCounter (
        .clk(clk),
        .nrst(nrst),
        .rt(rt)
    );

    // ****************************************
    // Command decode
    // ****************************************
    logic takeCmd, isReserved, isBlocked, isForward;
    logic inFlashWin, isFlashCmd, wrAllowed, wrByte, txDone;

    assign takeCmd = (state_r == ST_IDLE) && rxValid;
    assign isReserved = (rxByte == CMD_RESERVED_LONE) || (rxByte >= CMD_RESERVED_FIRST); // RQ9
    assign isBlocked = readProtect && ((rxByte == CMD_READ_REG) || (rxByte == CMD_WRITE_PROG)
        || (rxByte == CMD_READ_PROG) || (rxByte == CMD_STEP) || (rxByte == CMD_STUFF)
        || (rxByte == CMD_EXEC)); // RQ3
    // Write data memory falls through to forwarding even when protected
    assign isForward = !isReserved && !isBlocked && (rxByte != CMD_READ_REV)
        && (rxByte != CMD_READ_STATUS) && (rxByte != CMD_READ_RUNTIME)
        && (rxByte != CMD_WRITE_REG); // RQ10

    // Write gating is checked per byte since the address walks
    assign inFlashWin = (addr_r >= FLASH_CTL_LO) && (addr_r <= FLASH_CTL_HI);
    assign isFlashCmd = (addr_r == FLASH_CMD_ADDR);
    assign wrAllowed = !readProtect
        || (inFlashWin && (!isFlashCmd || rxByte == MASS_ERASE_CODE)); // RQ1 RQ2
    assign wrByte = (state_r == ST_WR_DATA) && rxValid;
    assign txDone = (state_r == ST_REPLY) && txReady;

    // Next state; a link break drops any command in progress
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        wrCount_nxt = wrCount_r;
        txByte_nxt = txByte_r;
        replyLow_nxt = replyLow_r;
        replyLeft_nxt = replyLeft_r;
        unique case (state_r)
            ST_IDLE: begin
                if (rxValid) begin
                    if (rxByte == CMD_READ_REV) begin
                        // Major byte goes first
                        txByte_nxt = REV_WORD[15:8]; // RQ4
                        replyLow_nxt = REV_WORD[7:0];
                        replyLeft_nxt = 2'h2;
                        state_nxt = ST_REPLY;
                    end else if (rxByte == CMD_READ_STATUS) begin
                        txByte_nxt = statusByte; // RQ5
                        replyLeft_nxt = 2'h1;
                        state_nxt = ST_REPLY;
                    end else if (rxByte == CMD_READ_RUNTIME) begin
                        // Both bytes snapshot together so the pair is consistent
                        txByte_nxt = rt.count[15:8]; // RQ6
                        replyLow_nxt = rt.count[7:0];
                        replyLeft_nxt = 2'h2;
                        state_nxt = ST_REPLY;
                    end else if (rxByte == CMD_WRITE_REG) begin
                        state_nxt = ST_WR_AH;
                    end else if (isBlocked) begin
                        state_nxt = ST_DISCARD;
                    end else if (isForward) begin
                        state_nxt = ST_FWD;
                    end
                end
            end
            ST_WR_AH: begin
                if (rxValid) begin
                    addr_nxt = {rxByte[3:0], addr_r[7:0]};
                    state_nxt = ST_WR_AL;
                end
            end
            ST_WR_AL: begin
                if (rxValid) begin
                    addr_nxt = {addr_r[11:8], rxByte};
                    state_nxt = ST_WR_CNT;
                end
            end
            ST_WR_CNT: begin
                // A count of zero means 256 bytes
                if (rxValid) begin
                    wrCount_nxt = rxByte;
                    state_nxt = ST_WR_DATA;
                end
            end
            ST_WR_DATA: begin
                if (rxValid) begin
                    addr_nxt = addr_r + 12'h001;
                    wrCount_nxt = wrCount_r - 8'h01;
                    if (wrCount_r == 8'h01) begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_REPLY: begin
                if (txReady) begin
                    if (replyLeft_r == 2'h1) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        txByte_nxt = replyLow_r;
                    end
                    replyLeft_nxt = replyLeft_r - 2'h1;
                end
            end
            ST_FWD: begin
                if (cmdDone) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_DISCARD: begin
                state_nxt = ST_DISCARD;
            end
        endcase
        if (linkBreak) begin
            state_nxt = ST_IDLE;
            replyLeft_nxt = LEFT_RESET;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            addr_r <= ADDR_RESET;
            wrCount_r <= BYTE_RESET;
            txByte_r <= BYTE_RESET;
            replyLow_r <= BYTE_RESET;
            replyLeft_r <= LEFT_RESET;
            runPrev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            wrCount_r <= wrCount_nxt;
            txByte_r <= txByte_nxt;
            replyLow_r <= replyLow_nxt;
            replyLeft_r <= replyLeft_nxt;
            runPrev_r <= cpuRunning;
        end
    end

    // Register write strobes, one cycle after the data byte
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regWrEn_r <= 1'b0;
            regWrRefused_r <= 1'b0;
            regWrAddr_r <= ADDR_RESET;
            regWrData_r <= BYTE_RESET;
        end else begin
            regWrEn_r <= wrByte && wrAllowed; // RQ1 RQ2
            regWrRefused_r <= wrByte && !wrAllowed;
            regWrAddr_r <= wrByte ? addr_r : regWrAddr_r;
            regWrData_r <= wrByte ? rxByte : regWrData_r;
        end
    end

    // Command hand-off and forwarded data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmdStart_r <= 1'b0;
            cmdRefused_r <= 1'b0;
            cmdCode_r <= BYTE_RESET;
            fwdValid_r <= 1'b0;
            fwdByte_r <= BYTE_RESET;
        end else begin
            // Only forwarded codes start the debug unit; local replies stay local
            cmdStart_r <= takeCmd && isForward; // RQ10
            cmdRefused_r <= takeCmd && isBlocked; // RQ3
            cmdCode_r <= takeCmd ? rxByte : cmdCode_r;
            fwdValid_r <= (state_r == ST_FWD) && rxValid && !cmdDone;
            fwdByte_r <= rxValid ? rxByte : fwdByte_r;
        end
    end

    assign txByte = txByte_r;
    assign txValid = (state_r == ST_REPLY);
    assign regWrEn = regWrEn_r;
    assign regWrRefused = regWrRefused_r;
    assign regWrAddr = regWrAddr_r;
    assign regWrData = regWrData_r;
    assign cmdStart = cmdStart_r;
    assign cmdRefused = cmdRefused_r;
    assign cmdCode = cmdCode_r;
    assign fwdValid = fwdValid_r;
    assign fwdByte = fwdByte_r;

    // Checker helpers: which reply byte is waiting, so the checks need no open-ended waits
    logic revHiWait_r, statWait_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            revHiWait_r <= 1'b0;
            statWait_r <= 1'b0;
        end else begin
            revHiWait_r <= (takeCmd && !linkBreak && rxByte == CMD_READ_REV)
                || (revHiWait_r && !txDone && !linkBreak);
            statWait_r <= (takeCmd && !linkBreak && rxByte == CMD_READ_STATUS)
                || (statWait_r && !txDone && !linkBreak);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    refuse_regs_a: assert property (@(posedge clk) disable iff (!nrst) // RQ1
        (wrByte && readProtect && !inFlashWin) |=> (!regWrEn && regWrRefused))
        else $error("protected write outside flash control passed");
    erase_only_a: assert property (@(posedge clk) disable iff (!nrst) // RQ2
        (wrByte && readProtect && isFlashCmd && rxByte != MASS_ERASE_CODE) |=> !regWrEn)
        else $error("non-erase flash command passed under protection");
    block_cmds_a: assert property (@(posedge clk) disable iff (!nrst) // RQ3
        (takeCmd && !linkBreak && readProtect && (rxByte == CMD_STEP || rxByte == CMD_READ_REG))
        |=> (cmdRefused && !cmdStart && state_r == ST_DISCARD))
        else $error("protected command was not refused");
    rev_order_a: assert property (@(posedge clk) disable iff (!nrst) // RQ4
        (takeCmd && !linkBreak && rxByte == CMD_READ_REV) |=> (txValid && txByte == REV_WORD[15:8]))
        else $error("revision high byte not sent first");
    rev_low_a: assert property (@(posedge clk) disable iff (!nrst) // RQ4
        (revHiWait_r && txDone && !linkBreak) |=> (txValid && txByte == REV_WORD[7:0]))
        else $error("revision low byte did not follow");
    stat_once_a: assert property (@(posedge clk) disable iff (!nrst) // RQ5
        (takeCmd && !linkBreak && rxByte == CMD_READ_STATUS)
        |=> (txValid && txByte == $past(statusByte)))
        else $error("status reply byte wrong");
    stat_single_a: assert property (@(posedge clk) disable iff (!nrst) // RQ5
        (statWait_r && txDone && !linkBreak) |=> !txValid)
        else $error("status reply not a single byte");
    rsvd_nop_a: assert property (@(posedge clk) disable iff (!nrst) // RQ9
        (takeCmd && isReserved) |=> (state_r == ST_IDLE && !txValid && !cmdStart
        && !cmdRefused && !regWrEn && !fwdValid))
        else $error("reserved code was acted on");
    wrdm_allow_a: assert property (@(posedge clk) disable iff (!nrst) // RQ10
        (takeCmd && rxByte == CMD_WRITE_DATA) |=> (cmdStart && !cmdRefused))
        else $error("write data memory was refused");
endmodule

//--- tb/dcd_host_model.sv
// ****************************************
// Debug host adapter on the link side
// ****************************************
module dcd_host_model (
    // Clock
    input wire logic clk,
    // Bytes to the device
    output logic [7:0] rxByte,
    output logic rxValid,
    // Reply bytes from the device
    input wire logic [7:0] txByte,
    input wire logic txValid,
    output logic txReady
);
    timeunit 1ns;
    timeprecision 1ns;

    // Link idle at time zero
    initial begin
        rxByte = 8'h00;
        rxValid = 1'b0;
        txReady = 1'b0;
    end

    // One byte per pulse; a released byte shows its inverse so stale data never looks valid
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        rxByte <= b;
        rxValid <= 1'b1;
        @(posedge clk);
        rxValid <= 1'b0;
        rxByte <= ~b;
    endtask

    // Take one reply byte after a stall; bounded so a silent device cannot hang us
    task automatic recv(input int stall, output logic [7:0] b, output logic ok);
        ok = 1'b0;
        b = 8'h00;
        repeat (stall + 1) @(posedge clk);
        txReady <= 1'b1;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(posedge clk);
            if (txValid === 1'b1) begin
                b = txByte;
                ok = 1'b1;
            end
        end
        txReady <= 1'b0;
    endtask
endmodule

//--- tb/dcd_top_tb.sv
module dcd_top_tb
    import dcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Signals and instances
    // ****************************************
    localparam logic [15:0] REV = 16'h0100;
    localparam logic [7:0] ERASE = 8'h5a;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic linkBreak = 1'b0;
    logic readProtect = 1'b0;
    logic [7:0] statusByte = 8'h00;
    logic cpuRunning = 1'b0;
    logic cmdDone = 1'b0;
    logic [7:0] rxByte, txByte, regWrData, cmdCode, fwdByte;
    logic rxValid, txValid, txReady, regWrEn, regWrRefused;
    logic cmdStart, cmdRefused, fwdValid;
    logic [11:0] regWrAddr;
    int err_total = 0;
    int tests_run = 0;

    dcd_top #(.REV_WORD(REV), .FLASH_CTL_LO(12'hff0), .FLASH_CTL_HI(12'hfff),
        .FLASH_CMD_ADDR(12'hff0), .MASS_ERASE_CODE(ERASE)) dcd_top_i (
        .clk(clk), .nrst(nrst), .rxByte(rxByte), .rxValid(rxValid),
        .linkBreak(linkBreak), .txByte(txByte), .txValid(txValid), .txReady(txReady),
        .readProtect(readProtect), .statusByte(statusByte), .cpuRunning(cpuRunning),
        .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData),
        .regWrRefused(regWrRefused), .cmdStart(cmdStart), .cmdCode(cmdCode),
        .cmdRefused(cmdRefused), .fwdValid(fwdValid), .fwdByte(fwdByte), .cmdDone(cmdDone));

    dcd_host_model dcd_host_model_i (.clk(clk), .rxByte(rxByte), .rxValid(rxValid),
        .txByte(txByte), .txValid(txValid), .txReady(txReady));

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Reply byte with timeout; a silent device ends the run at once
    task automatic get(input int stall, output logic [7:0] b);
        logic ok;
        dcd_host_model_i.recv(stall, b, ok);
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH t=%0t no reply got=%h exp=%h", $time, 1'b0, 1'b1);
            tally_and_finish();
        end
    endtask

    // Two-byte read, high byte first
    task automatic rd16(input logic [7:0] code, input int stall, output logic [15:0] w);
        dcd_host_model_i.send(code);
        get(stall, w[15:8]);
        get(0, w[7:0]);
        #1;
    endtask

    // Register write of one byte, then judge the write port
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic ok);
        dcd_host_model_i.send(CMD_WRITE_REG);
        #1;
        check({14'h0, cmdStart, cmdRefused}, 16'h0);
        dcd_host_model_i.send({4'h0, a[11:8]});
        dcd_host_model_i.send(a[7:0]);
        dcd_host_model_i.send(8'h01);
        dcd_host_model_i.send(d);
        #1;
        check({14'h0, regWrEn, regWrRefused}, {14'h0, ok, ~ok});
        if (ok) begin
            check({4'h0, regWrAddr}, {4'h0, a});
            check({8'h0, regWrData}, {8'h0, d});
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_rev_status();
        logic [15:0] w;
        logic [7:0] b;
        rd16(CMD_READ_REV, 0, w);
        check(w, REV);
        check({15'h0, txValid}, 16'h0);
        @(posedge clk);
        statusByte <= 8'ha5;
        dcd_host_model_i.send(CMD_READ_STATUS);
        get(3, b);
        #1;
        check({8'h0, b}, 16'h00a5);
        check({15'h0, txValid}, 16'h0);
    endtask

    task automatic sc_runtime();
        logic [15:0] w, w2;
        rd16(CMD_READ_RUNTIME, 2, w);
        check(w, 16'h0000);
        @(posedge clk);
        cpuRunning <= 1'b1;
        repeat (40) @(posedge clk);
        cpuRunning <= 1'b0;
        rd16(CMD_READ_RUNTIME, 0, w);
        check({15'h0, w >= 16'd37 && w <= 16'd42}, 16'h1);
        rd16(CMD_READ_RUNTIME, 0, w2);
        check(w2, w);
        @(posedge clk);
        cpuRunning <= 1'b1;
        repeat (66000) @(posedge clk);
        rd16(CMD_READ_RUNTIME, 0, w);
        check(w, 16'hffff);
        @(posedge clk);
        cpuRunning <= 1'b0;
    endtask

    task automatic sc_reserved();
        logic [7:0] codes [4] = '{CMD_RESERVED_LONE, CMD_RESERVED_FIRST, 8'h80, 8'hff};
        logic act;
        foreach (codes[i]) begin
            act = 1'b0;
            dcd_host_model_i.send(codes[i]);
            repeat (4) begin
                @(posedge clk);
                act = act | txValid | cmdStart | cmdRefused | regWrEn;
            end
            check({15'h0, act}, 16'h0);
        end
    endtask

    // Reset in the middle of a reply drops it; the next command works as before
    task automatic sc_reset();
        logic [15:0] w;
        dcd_host_model_i.send(CMD_READ_REV);
        #1;
        check({15'h0, txValid}, 16'h1);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        check({15'h0, txValid}, 16'h0);
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd16(CMD_READ_REV, 1, w);
        check(w, REV);
    endtask

    task automatic sc_protect();
        logic [7:0] codes [6] = '{CMD_READ_REG, CMD_WRITE_PROG, CMD_READ_PROG,
            CMD_STEP, CMD_STUFF, CMD_EXEC};
        @(posedge clk);
        readProtect <= 1'b1;
        foreach (codes[i]) begin
            dcd_host_model_i.send(codes[i]);
            #1;
            check({14'h0, cmdRefused, cmdStart}, 16'h2);
            @(posedge clk);
            linkBreak <= 1'b1;
            @(posedge clk);
            linkBreak <= 1'b0;
        end
        dcd_host_model_i.send(CMD_WRITE_DATA);
        #1;
        check({7'h0, cmdStart, cmdCode}, {8'h01, CMD_WRITE_DATA});
        dcd_host_model_i.send(8'h77);
        #1;
        check({7'h0, fwdValid, fwdByte}, 16'h0177);
        @(posedge clk);
        cmdDone <= 1'b1;
        @(posedge clk);
        cmdDone <= 1'b0;
        wr(12'h123, 8'h44, 1'b0);
        wr(12'hff0, 8'h11, 1'b0);
        wr(12'hff0, ERASE, 1'b1);
        wr(12'hff3, 8'h33, 1'b1);
        @(posedge clk);
        readProtect <= 1'b0;
        wr(12'h123, 8'h44, 1'b1);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        sc_rev_status();
        sc_runtime();
        sc_reserved();
        sc_reset();
        sc_protect();
        tally_and_finish();
    end
endmodule
